/* logic/adc_port_map.svh */
/*
  constants of the serial SAR conversion port: frame edge numbers,
  word layout and timing counts. assumes a 10 MHz system clock.
*/
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

`define ADC_RES_BITS        12
`define ADC_LEAD_ZEROS      3
`define ADC_FRAME_EDGES     16
`define ADC_TRACK_EDGE      14
`define ADC_MSB_EDGE        4
`define ADC_LSB_EDGE        15
`define ADC_PD_FIRST_EDGE   3
`define ADC_PD_LAST_EDGE    13
`define ADC_EDGE_W          5
`define ADC_RESTART_CYCLES  16
`define ADC_ACQ_CYCLES_FULL 3
`define ADC_CLK_PERIOD_NS   100
`define ADC_ACQ_MIN_NS      125
`define ADC_ACQ_MIN_CYC     ((`ADC_ACQ_MIN_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_ACQ_CNT_W       4

`endif

/* logic/adc_port_pkg.sv */
/*
  types of the serial SAR conversion port: power modes and frame states.
  assumes nothing beyond a SystemVerilog compiler.
*/
package adc_port_pkg;
    typedef enum logic [2:0] {
        PWR_NORMAL  = 3'h1,
        PWR_PARTIAL = 3'h2,
        PWR_FULL    = 3'h4
    } power_mode_t;

    typedef enum logic [2:0] {
        FRAME_ACQUIRE = 3'h1,
        FRAME_CONVERT = 3'h2,
        FRAME_DRAIN   = 3'h4
    } frame_state_t;
endpackage

/* logic/adc_link_if.sv */
/*
  carrier between the port controller, its pin synchroniser and its
  approximation engine. assumes all three run on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_map.svh"
interface adc_link_if #(parameter int RES_BITS = `ADC_RES_BITS);
    logic                cnvLevel;
    logic                cnvFall;
    logic                cnvRise;
    logic                sclkRise;
    logic                sclkFall;
    logic                sarStart;
    logic                sarStep;
    logic                sarBit;
    logic [RES_BITS-1:0] sarTrial;
    logic [RES_BITS-1:0] sarResult;

    modport syncSide (output cnvLevel, cnvFall, cnvRise, sclkRise, sclkFall);
    modport sarSide  (input sarStart, sarStep, output sarBit, sarTrial, sarResult);
    modport ctrlSide (input cnvLevel, cnvFall, cnvRise, sclkRise, sclkFall,
                      output sarStart, sarStep, input sarBit, sarTrial, sarResult);
endinterface
`default_nettype wire

/* logic/pin_edge_sync.sv */
/*
  two-flop synchronisers for the convert-start and serial-clock pins,
  with edge pulses taken from the settled stages only.
  assumes both pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
    input  wire logic    clk_sys,
    input  wire logic    rst,
    input  wire logic    clkEn,
    input  wire logic    cnvPin,
    input  wire logic    sclkPin,
    adc_link_if.syncSide link
);
    logic [1:0] cnvMeta;
    logic [1:0] sclkMeta;
    logic       cnvLast;
    logic       sclkLast;

    // idle high on convert-start so release from reset is no false start
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnvMeta  <= 2'h3;
            sclkMeta <= 2'h0;
            cnvLast  <= 1'b1;
            sclkLast <= 1'b0;
        end
        else if (clkEn)
        begin
            cnvMeta  <= {cnvMeta[0], cnvPin};
            sclkMeta <= {sclkMeta[0], sclkPin};
            cnvLast  <= cnvMeta[1];
            sclkLast <= sclkMeta[1];
        end
    end

    assign link.cnvLevel = cnvMeta[1];
    assign link.cnvFall  = clkEn & cnvLast & ~cnvMeta[1];
    assign link.cnvRise  = clkEn & ~cnvLast & cnvMeta[1];
    assign link.sclkRise = clkEn & ~sclkLast & sclkMeta[1];
    assign link.sclkFall = clkEn & sclkLast & ~sclkMeta[1];
endmodule
`default_nettype wire

/* logic/sar_engine.sv */
/*
  successive-approximation register: one bit decided per step, msb first.
  assumes the comparator answer is settled on clk_sys when a step comes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_map.svh"
module sar_engine #(
    parameter int RES_BITS = `ADC_RES_BITS
) (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   clkEn,
    input  wire logic   compareHigh,
    adc_link_if.sarSide link
);
    logic [RES_BITS-1:0] result;
    logic [RES_BITS-1:0] probe;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            result <= '0;
            probe  <= '0;
        end
        else if (clkEn)
        begin
            if (link.sarStart)
            begin
                result <= '0;
                probe  <= {1'b1, {(RES_BITS-1){1'b0}}};
            end
            else if (link.sarStep)
            begin
                if (compareHigh)
                    result <= result | probe;
                probe <= probe >> 1;
            end
        end
    end

    assign link.sarTrial  = result | probe;
    assign link.sarBit    = compareHigh;
    assign link.sarResult = result;
endmodule
`default_nettype wire

/* logic/serial_sar_adc_conversion_port.sv */
/*
  conversion control and serial readout of a 12-bit SAR converter.
  assumes convert-start and serial clock arrive asynchronously from a
  serial master and are sampled by clk_sys; the comparator answer comes
  from the analog front end already settled in the clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_map.svh"
// Contract
// - each convert-start falling edge starts a new conversion
// - track/hold goes to hold on the convert-start falling edge
// - track/hold returns to tracking on the fourteenth rising serial-clock edge
// - after power-up track/hold tracks at once
// - device rests in acquisition from edge fourteen to next start edge
// - a conversion takes sixteen serial-clock periods
// - serial output changes only on serial-clock rising edges; the code also clears it to zero on the start edge
// - approximation steps on the external serial clock
// - full-speed acquisition lasts three serial-clock cycles
// - partial power-down exit needs sixteen restart cycles
// - each conversion yields a twelve-bit successive-approximation result
// - word is three zeros, twelve bits msb first, one trailing zero
// - early convert-start return enters partial, then full power-down
// - start low past sixteenth falling edge releases output on next edge
module serial_sar_adc_conversion_port #(
    parameter int RES_BITS       = `ADC_RES_BITS,
    parameter int RESTART_CYCLES = `ADC_RESTART_CYCLES
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                clkEn,
    input  wire logic                convertStartStrobe,
    input  wire logic                serialClock,
    input  wire logic                compareHigh,
    output logic [RES_BITS-1:0]      dacTrial,
    output logic                     trackHold,
    output logic                     dataOut,
    output logic                     dataOutEn_n,
    output logic                     partialPowerDown,
    output logic                     fullPowerDown,
    output logic                     referenceEnable,
    output logic                     resultValid,
    output logic [RES_BITS-1:0]      conversionResult,
    output logic                     acquisitionShort
);
    adc_link_if #(.RES_BITS(RES_BITS)) link ();

    adc_port_pkg::frame_state_t      frame;
    adc_port_pkg::power_mode_t       powerMode;
    logic [`ADC_EDGE_W-1:0]          edgeCount;
    logic [`ADC_EDGE_W-1:0]          nextEdge;
    logic [5:0]                      restartLeft;
    logic [`ADC_ACQ_CNT_W-1:0]       acqCount;
    logic                            driveOut;
    logic                            calibrated;
    logic                            frameRise;
    logic                            earlyReturn;
    logic                            lateReturn;

    function automatic logic edgeIn(input logic [`ADC_EDGE_W-1:0] e, input int lo, input int hi);
        edgeIn = (int'(e) >= lo) && (int'(e) <= hi);
    endfunction

    pin_edge_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .cnvPin  (convertStartStrobe),
        .sclkPin (serialClock),
        .link    (link)
    );

    sar_engine #(.RES_BITS(RES_BITS)) u_sar (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .clkEn       (clkEn),
        .compareHigh (compareHigh),
        .link        (link)
    );

    assign frameRise = link.sclkRise && (frame == adc_port_pkg::FRAME_CONVERT)
                       && (edgeCount < 5'(`ADC_FRAME_EDGES));
    assign nextEdge  = edgeCount + 5'h1;

    // the engine decides bit n on the same edge that shifts it out
    assign link.sarStart = link.cnvFall;
    assign link.sarStep  = frameRise && edgeIn(nextEdge, `ADC_MSB_EDGE, `ADC_LSB_EDGE);
    assign dacTrial      = link.sarTrial;

    // frame sequencing
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            frame <= adc_port_pkg::FRAME_ACQUIRE;
        else if (clkEn)
        begin
            if (link.cnvFall)
                frame <= adc_port_pkg::FRAME_CONVERT;
            else
            begin
                unique case (frame)
                    adc_port_pkg::FRAME_ACQUIRE:
                        frame <= adc_port_pkg::FRAME_ACQUIRE;
                    adc_port_pkg::FRAME_CONVERT:
                        if (link.sclkFall && edgeCount == 5'(`ADC_FRAME_EDGES))
                            frame <= link.cnvLevel ? adc_port_pkg::FRAME_ACQUIRE
                                                   : adc_port_pkg::FRAME_DRAIN;
                    adc_port_pkg::FRAME_DRAIN:
                        if (link.sclkRise || link.cnvRise)
                            frame <= adc_port_pkg::FRAME_ACQUIRE;
                    default:
                        frame <= adc_port_pkg::FRAME_ACQUIRE;
                endcase
            end
        end
    end

    // rising serial-clock edges since the start edge; saturates at the frame length
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            edgeCount <= '0;
        else if (clkEn)
        begin
            if (link.cnvFall)
                edgeCount <= '0;
            else if (frameRise)
                edgeCount <= nextEdge;
        end
    end

    // track/hold control
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            trackHold <= 1'b1;
        else if (clkEn)
        begin
            if (link.cnvFall)
                trackHold <= 1'b0;
            else if (frameRise && nextEdge == 5'(`ADC_TRACK_EDGE))
                trackHold <= 1'b1;
        end
    end

    // serial output word: leading zeros, result msb first, trailing zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            dataOut <= 1'b0;
        else if (clkEn)
        begin
            if (link.cnvFall)
                dataOut <= 1'b0;
            else if (frameRise)
                dataOut <= link.sarStep ? link.sarBit : 1'b0;
        end
    end

    // output driver: on at the start edge, off after an overrun frame
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            driveOut <= 1'b0;
        else if (clkEn)
        begin
            if (link.cnvFall)
                driveOut <= 1'b1;
            else if (frame == adc_port_pkg::FRAME_DRAIN && (link.sclkRise || link.cnvRise))
                driveOut <= 1'b0;
        end
    end
    assign dataOutEn_n = ~driveOut;

    // result capture; the first frame after reset only calibrates
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            conversionResult <= '0;
            resultValid      <= 1'b0;
            calibrated       <= 1'b0;
        end
        else if (clkEn)
        begin
            if (link.cnvFall)
                resultValid <= 1'b0;
            else if (frameRise && nextEdge == 5'(`ADC_FRAME_EDGES))
            begin
                conversionResult <= link.sarResult;
                resultValid      <= calibrated && restartLeft == '0
                                    && powerMode == adc_port_pkg::PWR_NORMAL;
                calibrated       <= 1'b1;
            end
        end
    end

    // convert-start return position decides the power mode
    assign earlyReturn = link.cnvRise && frame == adc_port_pkg::FRAME_CONVERT
                         && edgeIn(edgeCount, `ADC_PD_FIRST_EDGE, `ADC_PD_LAST_EDGE);
    assign lateReturn  = link.cnvRise && frame != adc_port_pkg::FRAME_ACQUIRE
                         && edgeCount >= 5'(`ADC_TRACK_EDGE);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            powerMode <= adc_port_pkg::PWR_NORMAL;
        else if (clkEn)
        begin
            if (earlyReturn)
            begin
                unique case (powerMode)
                    adc_port_pkg::PWR_NORMAL:  powerMode <= adc_port_pkg::PWR_PARTIAL;
                    adc_port_pkg::PWR_PARTIAL: powerMode <= adc_port_pkg::PWR_FULL;
                    adc_port_pkg::PWR_FULL:    powerMode <= adc_port_pkg::PWR_FULL;
                    default:                   powerMode <= adc_port_pkg::PWR_NORMAL;
                endcase
            end
            else if (lateReturn)
                powerMode <= adc_port_pkg::PWR_NORMAL;
        end
    end
    assign partialPowerDown = powerMode == adc_port_pkg::PWR_PARTIAL;
    assign fullPowerDown    = powerMode == adc_port_pkg::PWR_FULL;
    assign referenceEnable  = powerMode != adc_port_pkg::PWR_FULL;

    // wake-up restart window; results stay flagged invalid until it runs out
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            restartLeft <= '0;
        else if (clkEn)
        begin
            if (lateReturn && powerMode != adc_port_pkg::PWR_NORMAL)
                restartLeft <= 6'(RESTART_CYCLES);
            else if (link.sclkRise && restartLeft != '0)
                restartLeft <= restartLeft - 6'h1;
        end
    end

    // flags a start edge that came while tracking and cut the tracking time below the minimum;
    // the master owns this timing, the flag only makes a breach visible
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            acqCount         <= '0;
            acquisitionShort <= 1'b0;
        end
        else if (clkEn)
        begin
            if (link.cnvFall)
            begin
                acquisitionShort <= trackHold && acqCount < 4'(`ADC_ACQ_MIN_CYC);
                acqCount         <= '0;
            end
            else if (trackHold && acqCount != '1)
                acqCount <= acqCount + 4'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_startFrame;
        link.cnvFall |=> frame == adc_port_pkg::FRAME_CONVERT && edgeCount == '0;
    endproperty
    a_startFrame: assert property (p_startFrame)
        else $error("start edge did not open a frame");

    property p_holdOnStart;
        link.cnvFall |=> !trackHold && dataOutEn_n == 1'b0 && !dataOut;
    endproperty
    a_holdOnStart: assert property (p_holdOnStart)
        else $error("start edge did not hold and drive low");

    property p_trackAt14;
        frameRise && edgeCount == 5'd13 |=> trackHold;
    endproperty
    a_trackAt14: assert property (p_trackAt14)
        else $error("no return to tracking at edge fourteen");

    property p_trackAfterReset;
        $fell(rst) |-> trackHold && powerMode == adc_port_pkg::PWR_NORMAL;
    endproperty
    a_trackAfterReset: assert property (p_trackAfterReset)
        else $error("not tracking after reset");

    property p_acquireStays;
        frame == adc_port_pkg::FRAME_ACQUIRE && trackHold && !link.cnvFall |=> trackHold;
    endproperty
    a_acquireStays: assert property (p_acquireStays)
        else $error("left acquisition without a start edge");

    property p_frameLength;
        frame == adc_port_pkg::FRAME_CONVERT && link.sclkFall && !link.cnvFall
            && edgeCount == 5'(`ADC_FRAME_EDGES) |=> frame != adc_port_pkg::FRAME_CONVERT;
    endproperty
    a_frameLength: assert property (p_frameLength)
        else $error("frame did not end after sixteen periods");

    property p_outOnRise;
        clkEn && $changed(dataOut) |-> $past(link.sclkRise) || $past(link.cnvFall);
    endproperty
    a_outOnRise: assert property (p_outOnRise)
        else $error("serial output moved off a rising edge");

    property p_zeroSlots;
        frameRise && (edgeCount < 5'd3 || edgeCount == 5'd15) |=> !dataOut;
    endproperty
    a_zeroSlots: assert property (p_zeroSlots)
        else $error("pad bit not zero");

    property p_release;
        frame == adc_port_pkg::FRAME_DRAIN && !link.cnvFall
            && (link.sclkRise || link.cnvRise) |=> dataOutEn_n;
    endproperty
    a_release: assert property (p_release)
        else $error("output not released after overrun");

    property p_partialEntry;
        earlyReturn && powerMode == adc_port_pkg::PWR_NORMAL |=> partialPowerDown;
    endproperty
    a_partialEntry: assert property (p_partialEntry)
        else $error("partial power-down not entered");

    property p_restart;
        lateReturn && powerMode != adc_port_pkg::PWR_NORMAL |=> restartLeft == 6'(RESTART_CYCLES)
            && powerMode == adc_port_pkg::PWR_NORMAL && referenceEnable;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart window not armed on wake");

    property p_msbSlot;
        frameRise && edgeCount == 5'd3 |-> link.sarStep ##1 dataOut == $past(compareHigh);
    endproperty
    a_msbSlot: assert property (p_msbSlot)
        else $error("msb not shifted on edge four");
endmodule
`default_nettype wire

/* bench/adc_master_model.sv */
/*
  serial master partner: drives convert-start and the serial clock with
  clk_sys-timed frames and records what it sees on the data output.
  assumes clk_sys at 100 ns, serial clock period 8 clk_sys (800 ns).
*/
`timescale 1ns/1ps
`default_nettype none
module adc_master_model (
    input  wire logic clk_sys,
    output var logic  convertStartStrobe,
    output var logic  serialClock,
    input  wire logic dataOut,
    input  wire logic dataOutEn_n,
    input  wire logic trackHold
);
    logic [15:0] word;
    logic [15:0] early;
    logic [15:0] thSeen;
    logic [15:0] enSeen;

    // start high and clock still: the clock only runs inside frames
    initial
    begin
        convertStartStrobe = 1'b1;
        serialClock        = 1'b0;
    end

    // riseBack is the rise after which start returns high; 0 leaves it low
    task automatic frame(input int riseBack);
        @(posedge clk_sys);
        convertStartStrobe <= 1'b0;
        // setup before the first rise; tracking from rise fourteen to frame end covers the acquisition minimum
        repeat (8) @(posedge clk_sys);
        for (int n = 1; n <= 16; n++)
        begin
            serialClock <= 1'b1;
            repeat (2) @(posedge clk_sys);
            if (n == riseBack)
                convertStartStrobe <= 1'b1;
            @(posedge clk_sys);
            serialClock <= 1'b0;
            repeat (2) @(posedge clk_sys);
            early[16-n] = dataOut;
            repeat (3) @(posedge clk_sys);
            word[16-n]   = dataOut;
            thSeen[16-n] = trackHold;
            enSeen[16-n] = dataOutEn_n;
        end
    endtask

    task automatic extraRise();
        serialClock <= 1'b1;
        repeat (3) @(posedge clk_sys);
        serialClock <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic releaseStart();
        convertStartStrobe <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask

    // reference settling after full power-down exit: 2 ms of clk_sys
    task automatic waitPowerUp();
        repeat (20000) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* bench/test_serial_sar_adc_conversion_port.sv */
/*
  self-checking bench of the conversion port: frames from the master
  model, a clocked comparator model fed by dacTrial, checks of word,
  track/hold, output release and power modes.
  assumes the design files and adc_master_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module test_serial_sar_adc_conversion_port;
    logic        clk_sys;
    logic        rst;
    logic        clkEn;
    logic        convertStartStrobe;
    logic        serialClock;
    logic        compareHigh;
    logic [11:0] dacTrial;
    logic        trackHold;
    logic        dataOut;
    logic        dataOutEn_n;
    logic        partialPowerDown;
    logic        fullPowerDown;
    logic        referenceEnable;
    logic        resultValid;
    logic [11:0] conversionResult;
    logic        acquisitionShort;
    logic [11:0] ain;
    int          errTotal;
    int          nTests;

    serial_sar_adc_conversion_port serial_sar_adc_conversion_port_inst (
        .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .convertStartStrobe(convertStartStrobe), .serialClock(serialClock),
        .compareHigh(compareHigh), .dacTrial(dacTrial), .trackHold(trackHold),
        .dataOut(dataOut), .dataOutEn_n(dataOutEn_n),
        .partialPowerDown(partialPowerDown), .fullPowerDown(fullPowerDown),
        .referenceEnable(referenceEnable), .resultValid(resultValid),
        .conversionResult(conversionResult), .acquisitionShort(acquisitionShort)
    );

    adc_master_model adc_master_model_inst (
        .clk_sys(clk_sys), .convertStartStrobe(convertStartStrobe),
        .serialClock(serialClock), .dataOut(dataOut),
        .dataOutEn_n(dataOutEn_n), .trackHold(trackHold)
    );

    // comparator model: registered, since the trial code settles a clk late
    always @(posedge clk_sys)
        compareHigh <= (dacTrial <= ain);

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic testReset();
        `CHECK(trackHold, 1'b1)
        `CHECK(dataOutEn_n, 1'b1)
        `CHECK(referenceEnable, 1'b1)
        ain <= 12'h000;
        adc_master_model_inst.frame(15);
        // the first frame after reset only calibrates
        `CHECK(resultValid, 1'b0)
        $display("test reset done");
    endtask

    task automatic testConvert();
        logic [11:0] vals [3];
        vals = '{12'ha5c, 12'hfff, 12'h001};
        foreach (vals[i])
        begin
            ain <= vals[i];
            adc_master_model_inst.frame(15);
            `CHECK(adc_master_model_inst.word, {3'h0, vals[i], 1'b0})
            `CHECK(adc_master_model_inst.early, adc_master_model_inst.word)
            `CHECK(adc_master_model_inst.thSeen, 16'h0007)
            `CHECK(adc_master_model_inst.enSeen, 16'h0000)
            `CHECK(conversionResult, vals[i])
            `CHECK(resultValid, 1'b1)
            `CHECK(acquisitionShort, 1'b0)
            `CHECK(partialPowerDown, 1'b0)
        end
        $display("test convert done");
    endtask

    // a whole frame with the enable low must leave every output untouched
    task automatic testFreeze();
        ain   <= 12'h555;
        clkEn <= 1'b0;
        adc_master_model_inst.frame(15);
        `CHECK(conversionResult, 12'h001)
        `CHECK(trackHold, 1'b1)
        `CHECK(resultValid, 1'b1)
        clkEn <= 1'b1;
        adc_master_model_inst.frame(15);
        `CHECK(conversionResult, 12'h555)
        `CHECK(resultValid, 1'b1)
        $display("test freeze done");
    endtask

    task automatic testRelease();
        ain <= 12'h3c3;
        adc_master_model_inst.frame(0);
        `CHECK(dataOutEn_n, 1'b0)
        adc_master_model_inst.extraRise();
        `CHECK(dataOutEn_n, 1'b1)
        adc_master_model_inst.releaseStart();
        `CHECK(conversionResult, 12'h3c3)
        `CHECK(partialPowerDown, 1'b0)
        $display("test release done");
    endtask

    task automatic testPowerDown();
        ain <= 12'h7e1;
        adc_master_model_inst.frame(5);
        `CHECK({partialPowerDown, fullPowerDown, referenceEnable}, 3'h5)
        // leaving partial power-down arms the restart count too
        adc_master_model_inst.frame(15);
        `CHECK({partialPowerDown, fullPowerDown, referenceEnable}, 3'h1)
        `CHECK(resultValid, 1'b0)
        adc_master_model_inst.frame(5);
        `CHECK({partialPowerDown, fullPowerDown, referenceEnable}, 3'h5)
        adc_master_model_inst.frame(5);
        `CHECK(fullPowerDown, 1'b1)
        `CHECK(referenceEnable, 1'b0)
        adc_master_model_inst.frame(15);
        `CHECK({partialPowerDown, fullPowerDown, referenceEnable}, 3'h1)
        // restart count has only just been armed
        `CHECK(resultValid, 1'b0)
        adc_master_model_inst.waitPowerUp();
        adc_master_model_inst.frame(15);
        adc_master_model_inst.frame(15);
        `CHECK(resultValid, 1'b1)
        `CHECK(conversionResult, 12'h7e1)
        $display("test power-down done");
    endtask

    // frames take about 140 clk each, plus one 20000 clk settling wait
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        errTotal++;
        stopTest();
    end

    initial
    begin
        errTotal = 0;
        nTests   = 0;
        rst      = 1'b1;
        ain      = 12'h000;
        clkEn    = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        testReset();
        testConvert();
        testFreeze();
        testRelease();
        testPowerDown();
        stopTest();
    end
endmodule
`default_nettype wire
